// File: logic/port_c_consts.svh
// Contract
// R01 - fuse programmed: bit-6 pin is plain I/O; only power-on and brown-out reset (code: R08 overrides keep it input, pull-up on, input buffer off)
// R02 - fuse unprogrammed: bit-6 pin feeds reset circuitry, not usable as I/O
// R03 - bit-6 as reset input: direction, latch and pin-input reads return zero
// R04 - two-wire enabled: bit-5 pin detached from port, becomes serial clock line
// R05 - two-wire enabled: bit-4 pin detached from port, becomes serial data line
// R06 - two-wire inputs filtered, pulses under 50 ns rejected
// R07 - two-wire pins open-drain: pull low or release, never drive high
// R08 - bit-6 pull-up, direction, input-enable override enables equal the fuse; pull-up value 1
// R09 - bits 5,4 overrides follow two-wire enable; direction from interface drive
// R10 - bits 3..0 carry no overrides, all held at zero
// R11 - pins 5..0 also routable to converter input channel of same index
// R12 - with override enable low, pin attributes follow port register bits
`ifndef PORT_C_CONSTS_SVH
`define PORT_C_CONSTS_SVH
`define PIN_COUNT 7
`define RESET_PIN_IDX 6
`define SCL_PIN_IDX 5
`define SDA_PIN_IDX 4
`define ANALOG_PIN_COUNT 6
`define CLK_PERIOD_NS 10
`define SPIKE_FILTER_NS 50
// shortest pulse that passes; shorter runs are rejected
`define SPIKE_FILTER_CYC ((`SPIKE_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: logic/port_c_pkg.sv
package port_c_pkg;
   // per-pin override bundle
   typedef struct packed {
      logic pullup_override_en;
      logic pullup_override_val;
      logic dir_override_en;
      logic dir_override_val;
      logic pinval_override_en;
      logic pinval_override_val;
      logic input_en_override_en;
      logic input_en_override_val;
   } pin_override_t;
   // ordinary port register bits for all seven pins
   typedef struct packed {
      logic [6:0] dir;
      logic [6:0] out_latch;
   } port_regs_t;
endpackage

// File: logic/port_c_alt_function_override.sv
`timescale 1ns/1ns
`include "port_c_consts.svh"
module port_c_alt_function_override (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire port_c_pkg::port_regs_t port_regs,
   input wire logic global_pullup_disable,
   input wire logic reset_pin_disable_fuse,
   input wire logic two_wire_enable,
   input wire logic scl_drive_low,
   input wire logic sda_drive_low,
   input wire logic [6:0] pin_in,
   output logic [6:0] pin_out,
   output logic [6:0] pin_oe_n,
   output logic [6:0] pin_pullup_en,
   output logic [6:0] pin_input_en,
   output logic [6:0] dir_readback,
   output logic [6:0] out_latch_readback,
   output logic [6:0] pin_input_readback,
   output logic ext_reset_level,
   output logic scl_in,
   output logic sda_in,
   output logic [5:0] analog_pin_path
);
   port_c_pkg::pin_override_t ovr [7];
   logic [6:0] sync1_reg;
   logic [6:0] sync2_reg;
   logic [1:0] filt_reg;
   logic [3:0] filt_cnt_reg [2];
   logic [6:0] pin_out_next;
   logic [6:0] pin_oe_n_next;
   logic [6:0] pullup_next;
   logic [6:0] inen_next;
   logic [6:0] pin_val;

   // two-flop synchroniser for the pad inputs
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= 7'h00;
         sync2_reg <= 7'h00;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
      end
   end

   // override table per pin
   always_comb begin
      for (int i = 0; i < `PIN_COUNT; i++) begin
         ovr[i] = '0;
      end
      // R08 bit-6 overrides
      ovr[`RESET_PIN_IDX].pullup_override_en = reset_pin_disable_fuse;
      ovr[`RESET_PIN_IDX].pullup_override_val = 1'b1;
      ovr[`RESET_PIN_IDX].dir_override_en = reset_pin_disable_fuse;
      ovr[`RESET_PIN_IDX].input_en_override_en = reset_pin_disable_fuse;
      // R09 two-wire overrides
      // pull-up value is latch and disable combined; kept literal, not inverted
      ovr[`SCL_PIN_IDX].pullup_override_en = two_wire_enable;
      ovr[`SCL_PIN_IDX].pullup_override_val =
         port_regs.out_latch[`SCL_PIN_IDX] & global_pullup_disable;
      ovr[`SCL_PIN_IDX].dir_override_en = two_wire_enable;
      ovr[`SCL_PIN_IDX].dir_override_val = scl_drive_low;
      ovr[`SCL_PIN_IDX].pinval_override_en = two_wire_enable;
      ovr[`SDA_PIN_IDX].pullup_override_en = two_wire_enable;
      ovr[`SDA_PIN_IDX].pullup_override_val =
         port_regs.out_latch[`SDA_PIN_IDX] & global_pullup_disable;
      ovr[`SDA_PIN_IDX].dir_override_en = two_wire_enable;
      ovr[`SDA_PIN_IDX].dir_override_val = sda_drive_low;
      ovr[`SDA_PIN_IDX].pinval_override_en = two_wire_enable;
      // R10 bits 3..0 left at zero by the default above
   end

   // pin attribute muxes
   always_comb begin
      for (int i = 0; i < `PIN_COUNT; i++) begin
         // R12 port bits when not overridden
         pullup_next[i] = ovr[i].pullup_override_en ? ovr[i].pullup_override_val :
            (port_regs.out_latch[i] & ~port_regs.dir[i] & ~global_pullup_disable);
         pin_oe_n_next[i] = ~(ovr[i].dir_override_en ? ovr[i].dir_override_val :
            port_regs.dir[i]);
         pin_out_next[i] = ovr[i].pinval_override_en ? ovr[i].pinval_override_val :
            port_regs.out_latch[i];
         inen_next[i] = ovr[i].input_en_override_en ? ovr[i].input_en_override_val : 1'b1;
      end
      // R01 fuse programmed: R08 overrides hold bit 6 as input with pull-up on and input buffer off, not plain I/O
      // R02 unprogrammed fuse: pad driver off, pin given to reset
      if (!reset_pin_disable_fuse) begin
         pin_oe_n_next[`RESET_PIN_IDX] = 1'b1;
         pin_out_next[`RESET_PIN_IDX] = 1'b0;
      end
   end

   // registered pad controls
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= 7'h00;
         pin_oe_n <= 7'h7f;
         pin_pullup_en <= 7'h00;
         pin_input_en <= 7'h00;
      end else begin
         // R07 open-drain: value forced low, only the enable moves
         pin_out <= pin_out_next;
         pin_oe_n <= pin_oe_n_next;
         pin_pullup_en <= pullup_next;
         pin_input_en <= inen_next;
      end
   end

   // R06 spike filter: a level must hold the minimum time to pass
   generate
      for (genvar k = 0; k < 2; k++) begin : g_filt
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               filt_reg[k] <= 1'b1;
               filt_cnt_reg[k] <= 4'h0;
            end else if (sync2_reg[`SDA_PIN_IDX + k] == filt_reg[k]) begin
               filt_cnt_reg[k] <= 4'h0;
            end else if (filt_cnt_reg[k] == 4'(`SPIKE_FILTER_CYC - 1)) begin
               filt_reg[k] <= sync2_reg[`SDA_PIN_IDX + k];
               filt_cnt_reg[k] <= 4'h0;
            end else begin
               filt_cnt_reg[k] <= filt_cnt_reg[k] + 4'h1;
            end
         end
      end
   endgenerate

   // gated input value seen by the port
   assign pin_val = sync2_reg & inen_next;

   // readbacks and peripheral inputs
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dir_readback <= 7'h00;
         out_latch_readback <= 7'h00;
         pin_input_readback <= 7'h00;
         ext_reset_level <= 1'b1;
         scl_in <= 1'b1;
         sda_in <= 1'b1;
         analog_pin_path <= 6'h00;
      end else begin
         dir_readback <= port_regs.dir;
         out_latch_readback <= port_regs.out_latch;
         pin_input_readback <= pin_val;
         // R03 reset pin reads zero
         if (!reset_pin_disable_fuse) begin
            dir_readback[`RESET_PIN_IDX] <= 1'b0;
            out_latch_readback[`RESET_PIN_IDX] <= 1'b0;
            pin_input_readback[`RESET_PIN_IDX] <= 1'b0;
         end
         // R02 pin level to reset circuitry
         ext_reset_level <= reset_pin_disable_fuse | sync2_reg[`RESET_PIN_IDX];
         // R04 filtered clock to interface
         scl_in <= two_wire_enable ? filt_reg[1] : 1'b1;
         // R05 filtered data to interface
         sda_in <= two_wire_enable ? filt_reg[0] : 1'b1;
         // R11 converter path held on for all pins 5..0, no channel select
         analog_pin_path <= 6'h3f;
      end
   end
endmodule

// File: sim/port_c_chk.sv
`timescale 1ns/1ns
module port_c_chk (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire port_c_pkg::port_regs_t port_regs,
   input wire logic reset_pin_disable_fuse,
   input wire logic two_wire_enable,
   input wire logic scl_drive_low,
   input wire logic sda_drive_low,
   input wire logic [6:0] pin_in,
   input wire logic [6:0] pin_out,
   input wire logic [6:0] pin_oe_n,
   input wire logic [6:0] dir_readback,
   input wire logic ext_reset_level,
   input wire logic scl_in,
   input wire logic [5:0] analog_pin_path
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // clock line settled high, then a dip one cycle short of the filter
   sequence quiet_line;
      (two_wire_enable && pin_in[5]) [*8];
   endsequence
   sequence short_dip;
      !pin_in[5] [*4] ##1 pin_in[5];
   endsequence
   low_dir_a: assert property ($past(rst_n) |-> pin_oe_n[3:0] == ~$past(port_regs.dir[3:0]))
      else $error("plain pin direction wrong");
   low_out_a: assert property ($past(rst_n) |-> pin_out[3:0] == $past(port_regs.out_latch[3:0]))
      else $error("plain pin output wrong");
   scl_drive_a: assert property ($past(rst_n) && $past(two_wire_enable) |->
      pin_oe_n[5] == !$past(scl_drive_low)) else $error("clock line drive wrong");
   sda_drive_a: assert property ($past(rst_n) && $past(two_wire_enable) |->
      pin_oe_n[4] == !$past(sda_drive_low)) else $error("data line drive wrong");
   open_drain_a: assert property ($past(rst_n) && $past(two_wire_enable) |->
      pin_out[5:4] == 2'h0) else $error("two-wire pin driven high");
   rst_readback_a: assert property ($past(rst_n) && !$past(reset_pin_disable_fuse) |->
      dir_readback[6] == 1'h0) else $error("reset pin readback not zero");
   fuse_io_a: assert property ($past(rst_n) && $past(reset_pin_disable_fuse) |->
      ext_reset_level) else $error("reset level not idle");
   analog_on_a: assert property ($past(rst_n) |-> analog_pin_path == 6'h3f)
      else $error("analog path missing");
   spike_reject_a: assert property (quiet_line ##1 short_dip |-> scl_in [*8])
      else $error("spike reached clock input");
endmodule
bind port_c_alt_function_override port_c_chk i_port_c_chk (.*);

// File: sim/port_c_pads.sv
`timescale 1ns/1ns
module port_c_pads (
   input wire logic clk_sys,
   input wire logic [6:0] pin_out,
   input wire logic [6:0] pin_oe_n,
   input wire logic [6:0] pin_pullup_en,
   input wire logic [6:0] ext_en,
   input wire logic [6:0] ext_val,
   output logic [6:0] pin_level
);
   logic [6:0] float_reg = 7'h55;
   // a pad nobody holds wanders, so a stale level never passes
   always_ff @(posedge clk_sys) float_reg <= ~float_reg;
   // a low from either side wins the wire
   assign pin_level = ~(~pin_oe_n & ~pin_out) & ((ext_en & ext_val) |
      (~ext_en & (~pin_oe_n | pin_pullup_en | float_reg)));
endmodule

// File: sim/tb_port_c_alt_function_override.sv
`timescale 1ns/1ns
module tb_port_c_alt_function_override;
   port_c_pkg::port_regs_t port_regs = 14'h0000;
   logic clk_sys = 1'h0, rst_n = 1'h0, global_pullup_disable = 1'h0, tw, line;
   logic reset_pin_disable_fuse = 1'h0, two_wire_enable = 1'h0;
   logic scl_drive_low = 1'h0, sda_drive_low = 1'h0, ext_reset_level, scl_in, sda_in;
   logic [6:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, pin_input_en, dir_readback;
   logic [6:0] out_latch_readback, pin_input_readback, ext_en = 7'h7f, ext_val = 7'h7f;
   logic [6:0] e_oe = 7'h00, e_out = 7'h00, e_pu = 7'h00;
   logic [5:0] analog_pin_path;
   int err_total = 0, n_checks = 0, w;
   port_c_alt_function_override i_port_c_alt_function_override (.*);
   port_c_pads i_port_c_pads (.clk_sys, .pin_out, .pin_oe_n, .pin_pullup_en, .ext_en,
      .ext_val, .pin_level(pin_in));
   // free-running system clock
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic check(string nm, logic [6:0] exp, logic [6:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // main sequence, inputs move on falling edges only
   initial begin
      void'($urandom(21));
      repeat (20) @(negedge clk_sys);
      rst_n = 1'h1;
      for (int n = 0; n < 300; n++) begin
         {port_regs, global_pullup_disable, two_wire_enable, scl_drive_low} = 17'($urandom);
         {reset_pin_disable_fuse, sda_drive_low, ext_val} = 9'($urandom);
         @(negedge clk_sys);
         // reference model of the pad controls, one cycle late
         for (int i = 0; i < 6; i++) begin
            tw = two_wire_enable && i > 3;
            e_oe[i] = tw ? !(i == 5 ? scl_drive_low : sda_drive_low) : !port_regs.dir[i];
            e_out[i] = tw ? 1'h0 : port_regs.out_latch[i];
            e_pu[i] = port_regs.out_latch[i] & (tw ? global_pullup_disable :
               !port_regs.dir[i] & !global_pullup_disable);
         end
         check("oe_n", e_oe, pin_oe_n & 7'h3f);
         check("out", e_out, pin_out & 7'h3f);
         check("pullup", e_pu, pin_pullup_en & 7'h3f);
         check("dir_rb", port_regs.dir & {reset_pin_disable_fuse, 6'h3f}, dir_readback);
         check("lat_rb", port_regs.out_latch & {reset_pin_disable_fuse, 6'h3f},
            out_latch_readback);
         check("inen", 7'h3f, pin_input_en & 7'h3f);
         if (!reset_pin_disable_fuse) check("rst_oe", 7'h01, {6'h00, pin_oe_n[6]});
      end
      // reset-pin mode with every pad an input
      {port_regs, reset_pin_disable_fuse, two_wire_enable} = 16'h0000;
      // line drivers released so only the far side moves the pads
      scl_drive_low = 1'h0;
      sda_drive_low = 1'h0;
      repeat (5) @(negedge clk_sys);
      check("pin_rb", ext_val & 7'h3f, pin_input_readback);
      check("rst_lvl", {6'h00, ext_val[6]}, {6'h00, ext_reset_level});
      check("analog", 7'h3f, {1'h0, analog_pin_path});
      // four-cycle spikes rejected, long lows pass on both lines
      two_wire_enable = 1'h1;
      ext_val = 7'h7f;
      repeat (12) @(negedge clk_sys);
      for (int k = 4; k < 6; k++) begin
         ext_val[k] = 1'h0;
         repeat (4) @(negedge clk_sys);
         ext_val[k] = 1'h1;
         repeat (12) begin
            @(negedge clk_sys);
            check("spike", 7'h01, {6'h00, k == 5 ? scl_in : sda_in});
         end
         ext_val[k] = 1'h0;
         w = 0;
         do begin
            @(negedge clk_sys);
            line = k == 5 ? scl_in : sda_in;
            w++;
         end while (line !== 1'h0 && w < 20);
         check("long_low", 7'h00, {6'h00, line});
         if (w == 20) give_verdict();
         ext_val[k] = 1'h1;
         repeat (12) @(negedge clk_sys);
      end
      give_verdict();
   end
endmodule
